// ### rtl/scdp_pkg.sv
package scdp_pkg;

  // ==========================================================================
  // Register word indices and byte addresses
  // ==========================================================================
  localparam int REG_CONTROL_IDX = 0;
  localparam int REG_COMMAND_IDX = 1;
  localparam int REG_STATUS_IDX = 2;
  localparam int REG_PERIPH_PTR_IDX = 11;
  localparam int REG_MEM_PTR_IDX = 12;
  localparam int REG_WORD_COUNT_IDX = 13;

  localparam int AVS_ADDR_W = 6;
  localparam logic [AVS_ADDR_W-1:0] ADDR_CONTROL = AVS_ADDR_W'(REG_CONTROL_IDX * 4);
  localparam logic [AVS_ADDR_W-1:0] ADDR_COMMAND = AVS_ADDR_W'(REG_COMMAND_IDX * 4);
  localparam logic [AVS_ADDR_W-1:0] ADDR_STATUS = AVS_ADDR_W'(REG_STATUS_IDX * 4);
  localparam logic [AVS_ADDR_W-1:0] ADDR_PERIPH_PTR = AVS_ADDR_W'(REG_PERIPH_PTR_IDX * 4);
  localparam logic [AVS_ADDR_W-1:0] ADDR_MEM_PTR = AVS_ADDR_W'(REG_MEM_PTR_IDX * 4);
  localparam logic [AVS_ADDR_W-1:0] ADDR_WORD_COUNT = AVS_ADDR_W'(REG_WORD_COUNT_IDX * 4);

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int WORD_W = 16;
  localparam int SELECT_W = 4;
  localparam int CTRL_ADDR16_BIT = 0;
  localparam int DIR_BIT_15 = 15;
  localparam int NEG_BIT_15 = 14;
  localparam int NEG_BIT_16 = 15;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_DIR_BIT = 2;
  localparam int ST_CNT_NEG_N_BIT = 3;
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_ADDR16_BIT = 5;

  // ==========================================================================
  // Command codes written to the command register
  // ==========================================================================
  localparam logic [3:0] CMD_TRANSFER_MODE = 4'h1;
  localparam logic [3:0] CMD_IGNORE_REQUESTS = 4'h2;
  localparam logic [3:0] CMD_PULSE_COUNT = 4'h3;
  localparam logic [3:0] CMD_DIR_SET = 4'h4;
  localparam logic [3:0] CMD_DIR_CLEAR = 4'h5;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int IO_CYCLE_NS = 40;
  localparam int IO_CYCLE_CLKS = (IO_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 3;
  localparam logic [TMR_W-1:0] IO_TMR_LOAD = TMR_W'(IO_CYCLE_CLKS - 1);

  // ==========================================================================
  // Reset values and types
  // ==========================================================================
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  typedef enum logic [1:0] {MODE_IGNORE, MODE_TRANSFER, MODE_PULSE} scdp_mode_e;
  typedef enum logic [2:0] {S_IDLE, S_GRANT, S_IO, S_MEM, S_DONE} scdp_state_e;

endpackage

// ### rtl/scdp_avs.sv
`timescale 1ns/100ps
module scdp_avs
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic read_in,
  input wire logic [31:0] read_value_in,
  output logic waitrequest_out,
  output logic [31:0] readdata_out
);
  import scdp_pkg::*;

  typedef struct packed {
    logic rd_valid;
    logic [31:0] rdata;
  } scdp_avs_s;

  scdp_avs_s q_ff;
  scdp_avs_s nxt_q;

  // ==========================================================================
  // Read path: one wait cycle so read data comes from a register
  // ==========================================================================
  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.rd_valid = 1'b0;
    if (read_in && !q_ff.rd_valid)
    begin
      nxt_q.rd_valid = 1'b1;
      nxt_q.rdata = read_value_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q_ff <= '0;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign waitrequest_out = read_in && !q_ff.rd_valid;
  assign readdata_out = q_ff.rdata;

endmodule

// ### rtl/scdp_dma.sv
`timescale 1ns/100ps
module scdp_dma
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic [scdp_pkg::AVS_ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic TRANSFER_REQUEST_N_IN,
  output logic BUS_REQUEST_OUT,
  input wire logic BUS_GRANT_IN,
  output logic IO_STROBE_OUT,
  output logic IO_WRITE_OUT,
  output logic [scdp_pkg::SELECT_W-1:0] PERIPHERAL_ADDRESS_LINES_OUT,
  output logic IO_CONTROL_LINE_TWO_N_OUT,
  output logic [scdp_pkg::WORD_W-1:0] IO_DATA_OUT,
  input wire logic [scdp_pkg::WORD_W-1:0] IO_DATA_IN,
  output logic MEM_REQUEST_OUT,
  output logic MEM_WRITE_OUT,
  output logic [scdp_pkg::WORD_W-1:0] MEM_ADDRESS_OUT,
  output logic [scdp_pkg::WORD_W-1:0] MEM_WRITEDATA_OUT,
  input wire logic [scdp_pkg::WORD_W-1:0] MEM_READDATA_IN,
  input wire logic MEM_ACK_IN
);
  import scdp_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] periph_ptr;
    logic [WORD_W-1:0] mem_ptr;
    logic [WORD_W-1:0] word_count;
    logic addr16;
    logic dir_flag;
    scdp_mode_e mode;
    scdp_state_e state;
    logic xfer_out;
    logic pulse;
    logic last;
    logic [TMR_W-1:0] tmr;
    logic [WORD_W-1:0] data;
    logic bus_req;
    logic io_strobe;
    logic io_write;
    logic io_ctl_two_n;
    logic [SELECT_W-1:0] pa;
    logic mem_req;
    logic mem_write;
    logic [WORD_W-1:0] mem_addr;
  } scdp_dma_s;

  scdp_dma_s q_ff;
  scdp_dma_s nxt_q;
  logic dir_out;
  logic count_negative_n;
  logic count_is_zero;
  logic req_active;
  logic [31:0] read_value;
  logic [WORD_W-1:0] ptr_inc;
  logic [WORD_W-1:0] mem_word_addr;

  // ==========================================================================
  // Direction, count state and address derivation
  // ==========================================================================
  // Direction source
  assign dir_out = q_ff.addr16 ? q_ff.dir_flag : q_ff.mem_ptr[DIR_BIT_15];

  assign count_negative_n = q_ff.addr16 ? !q_ff.word_count[NEG_BIT_16] :
                                          !q_ff.word_count[NEG_BIT_15];

  assign count_is_zero = q_ff.addr16 ? (q_ff.word_count == WORD_RESET) :
                         (q_ff.word_count[NEG_BIT_15:0] == WORD_RESET[NEG_BIT_15:0]);

  assign req_active = (q_ff.mode != MODE_IGNORE) && !TRANSFER_REQUEST_N_IN;

  always_comb
  begin
    ptr_inc = q_ff.mem_ptr + 16'h0001;
    mem_word_addr = q_ff.mem_ptr;
    if (!q_ff.addr16)
    begin
      ptr_inc[DIR_BIT_15] = q_ff.mem_ptr[DIR_BIT_15];
      mem_word_addr[DIR_BIT_15] = 1'b0;
    end
  end

  // ==========================================================================
  // Register read mux
  // ==========================================================================
  always_comb
  begin
    read_value = 32'h0000_0000;
    unique case (AVS_ADDRESS_IN)
      ADDR_CONTROL: read_value[CTRL_ADDR16_BIT] = q_ff.addr16;
      ADDR_STATUS:
      begin
        read_value[ST_MODE_LSB +: 2] = q_ff.mode;
        read_value[ST_DIR_BIT] = dir_out;
        read_value[ST_CNT_NEG_N_BIT] = count_negative_n;
        read_value[ST_BUSY_BIT] = (q_ff.state != S_IDLE);
        read_value[ST_ADDR16_BIT] = q_ff.addr16;
      end
      ADDR_PERIPH_PTR: read_value[SELECT_W-1:0] = q_ff.periph_ptr[SELECT_W-1:0];
      ADDR_MEM_PTR: read_value[WORD_W-1:0] = q_ff.mem_ptr;
      ADDR_WORD_COUNT: read_value[WORD_W-1:0] = q_ff.word_count;
      default: read_value = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Transfer sequencer and register writes
  // ==========================================================================
  always_comb
  begin
    nxt_q = q_ff;
    unique case (q_ff.state)
      S_IDLE:
      begin
        if (req_active)
        begin
          nxt_q.bus_req = 1'b1;
          nxt_q.state = S_GRANT;
        end
      end
      S_GRANT:
      begin
        if (BUS_GRANT_IN)
        begin
          nxt_q.pulse = (q_ff.mode == MODE_PULSE);
          nxt_q.xfer_out = dir_out;
          nxt_q.last = count_is_zero;
          if (q_ff.mode == MODE_PULSE || !dir_out)
          begin
            nxt_q.io_strobe = 1'b1;
            nxt_q.io_write = 1'b0;
            nxt_q.pa = q_ff.periph_ptr[SELECT_W-1:0];
            nxt_q.io_ctl_two_n = count_is_zero;
            nxt_q.tmr = IO_TMR_LOAD;
            nxt_q.state = S_IO;
          end
          else
          begin
            nxt_q.mem_req = 1'b1;
            nxt_q.mem_write = 1'b0;
            nxt_q.mem_addr = mem_word_addr;
            nxt_q.state = S_MEM;
          end
        end
      end
      S_IO:
      begin
        if (q_ff.tmr != '0)
        begin
          nxt_q.tmr = q_ff.tmr - 3'h1;
        end
        else
        begin
          nxt_q.io_strobe = 1'b0;
          nxt_q.io_write = 1'b0;
          nxt_q.io_ctl_two_n = 1'b1;
          if (!q_ff.pulse && !q_ff.xfer_out)
          begin
            nxt_q.data = IO_DATA_IN;
            nxt_q.mem_req = 1'b1;
            nxt_q.mem_write = 1'b1;
            nxt_q.mem_addr = mem_word_addr;
            nxt_q.state = S_MEM;
          end
          else
          begin
            nxt_q.state = S_DONE;
          end
        end
      end
      S_MEM:
      begin
        if (MEM_ACK_IN)
        begin
          nxt_q.mem_req = 1'b0;
          nxt_q.mem_write = 1'b0;
          if (q_ff.xfer_out)
          begin
            nxt_q.data = MEM_READDATA_IN;
            nxt_q.io_strobe = 1'b1;
            nxt_q.io_write = 1'b1;
            nxt_q.pa = q_ff.periph_ptr[SELECT_W-1:0];
            nxt_q.io_ctl_two_n = q_ff.last;
            nxt_q.tmr = IO_TMR_LOAD;
            nxt_q.state = S_IO;
          end
          else
          begin
            nxt_q.state = S_DONE;
          end
        end
      end
      S_DONE:
      begin
        nxt_q.mem_ptr = ptr_inc;
        nxt_q.word_count = q_ff.word_count - 16'h0001;
        if (req_active && BUS_GRANT_IN)
        begin
          nxt_q.state = S_GRANT;
        end
        else
        begin
          nxt_q.bus_req = 1'b0;
          nxt_q.state = S_IDLE;
        end
      end
      default:
      begin
        nxt_q.state = S_IDLE;
      end
    endcase

    // Software writes land after the sequencer so they take precedence.
    if (AVS_WRITE_IN)
    begin
      unique case (AVS_ADDRESS_IN)
        ADDR_CONTROL: nxt_q.addr16 = AVS_WRITEDATA_IN[CTRL_ADDR16_BIT];
        ADDR_COMMAND:
        begin
          unique case (AVS_WRITEDATA_IN[3:0])
            CMD_TRANSFER_MODE: nxt_q.mode = MODE_TRANSFER;
            CMD_IGNORE_REQUESTS: nxt_q.mode = MODE_IGNORE;
            CMD_PULSE_COUNT: nxt_q.mode = MODE_PULSE;
            CMD_DIR_SET: nxt_q.dir_flag = 1'b1;
            CMD_DIR_CLEAR: nxt_q.dir_flag = 1'b0;
            default: nxt_q.mode = q_ff.mode;
          endcase
        end
        ADDR_PERIPH_PTR: nxt_q.periph_ptr = AVS_WRITEDATA_IN[WORD_W-1:0];
        ADDR_MEM_PTR: nxt_q.mem_ptr = AVS_WRITEDATA_IN[WORD_W-1:0];
        ADDR_WORD_COUNT: nxt_q.word_count = AVS_WRITEDATA_IN[WORD_W-1:0];
        default: nxt_q.mode = nxt_q.mode;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      q_ff <= '0;
      q_ff.mode <= MODE_IGNORE;
      q_ff.state <= S_IDLE;
      q_ff.io_ctl_two_n <= 1'b1;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  // ==========================================================================
  // Bus slave and outputs
  // ==========================================================================
  scdp_avs u_avs
  (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .read_in(AVS_READ_IN),
    .read_value_in(read_value),
    .waitrequest_out(AVS_WAITREQUEST_OUT),
    .readdata_out(AVS_READDATA_OUT)
  );

  assign BUS_REQUEST_OUT = q_ff.bus_req;
  assign IO_STROBE_OUT = q_ff.io_strobe;
  assign IO_WRITE_OUT = q_ff.io_write;
  assign PERIPHERAL_ADDRESS_LINES_OUT = q_ff.pa;
  assign IO_CONTROL_LINE_TWO_N_OUT = q_ff.io_ctl_two_n;
  assign IO_DATA_OUT = q_ff.data;
  assign MEM_REQUEST_OUT = q_ff.mem_req;
  assign MEM_WRITE_OUT = q_ff.mem_write;
  assign MEM_ADDRESS_OUT = q_ff.mem_addr;
  assign MEM_WRITEDATA_OUT = q_ff.data;

endmodule

// ### test/scdp_assertions.sv
`timescale 1ns/100ps
module scdp_assertions
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic BUS_REQUEST_OUT,
  input wire logic BUS_GRANT_IN,
  input wire logic IO_STROBE_OUT,
  input wire logic [scdp_pkg::SELECT_W-1:0] PERIPHERAL_ADDRESS_LINES_OUT,
  input wire logic IO_CONTROL_LINE_TWO_N_OUT,
  input wire logic MEM_REQUEST_OUT,
  input wire logic MEM_ACK_IN,
  input wire logic [scdp_pkg::WORD_W-1:0] MEM_ADDRESS_OUT
);
  import scdp_pkg::*;
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  sequence strobe_s;
    IO_STROBE_OUT [*4] ##1 !IO_STROBE_OUT;
  endsequence
  sequence mem_wait_s;
    MEM_REQUEST_OUT && !MEM_ACK_IN;
  endsequence
  bus_owner_a: assert property (
    (IO_STROBE_OUT || MEM_REQUEST_OUT) |-> BUS_REQUEST_OUT) else $error("no bus request");
  grant_first_a: assert property (
    ($rose(IO_STROBE_OUT) || $rose(MEM_REQUEST_OUT)) |-> $past(BUS_GRANT_IN))
    else $error("cycle before grant");
  strobe_len_a: assert property (
    $rose(IO_STROBE_OUT) |-> strobe_s) else $error("strobe length");
  io_fields_a: assert property (
    IO_STROBE_OUT && $past(IO_STROBE_OUT) |-> $stable(PERIPHERAL_ADDRESS_LINES_OUT)
    && $stable(IO_CONTROL_LINE_TWO_N_OUT)) else $error("io fields moved");
  line_idle_a: assert property (
    !BUS_REQUEST_OUT && !$past(BUS_REQUEST_OUT) |-> IO_CONTROL_LINE_TWO_N_OUT)
    else $error("line two low when idle");
  mem_hold_a: assert property (
    mem_wait_s |=> MEM_REQUEST_OUT && $stable(MEM_ADDRESS_OUT)) else $error("mem dropped");
  mem_end_a: assert property (
    MEM_REQUEST_OUT && MEM_ACK_IN |=> !MEM_REQUEST_OUT) else $error("mem not ended");
  one_cycle_a: assert property (
    !(IO_STROBE_OUT && MEM_REQUEST_OUT)) else $error("io and mem overlap");
  read_wait_a: assert property (
    $rose(AVS_READ_IN) |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
    else $error("read wait");
  write_go_a: assert property (
    AVS_WRITE_IN |-> !AVS_WAITREQUEST_OUT) else $error("write waited");
endmodule

// ### test/scdp_periph_model.sv
`timescale 1ns/100ps
module scdp_periph_model
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic strobe_in,
  input wire logic last_n_in,
  output logic request_n_out,
  output logic active_out,
  output logic [15:0] data_out
);
  logic [1:0] gap;
  logic stb_q;
  logic [15:0] word;
  // Off the strobe the data lines show the inverse word.
  assign data_out = strobe_in ? word : ~word;
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      request_n_out <= 1'b1;
      active_out <= 1'b0;
      word <= 16'h0001;
      gap <= 2'h3;
      stb_q <= 1'b0;
    end
    else
    begin
      stb_q <= strobe_in;
      gap <= strobe_in ? 2'h0 : (gap == 2'h3 ? gap : gap + 2'h1);
      if (stb_q && !strobe_in)
        word <= word + 16'h3331;
      if (start_in)
        active_out <= 1'b1;
      else if (strobe_in && last_n_in)
        active_out <= 1'b0;
      if (strobe_in)
        request_n_out <= 1'b1;
      else if (active_out && gap == 2'h3)
        request_n_out <= 1'b0;
    end
  end
endmodule

// ### test/tb_single_channel_dma_with_pulse_count.sv
`timescale 1ns/100ps
module tb_single_channel_dma_with_pulse_count;
  import scdp_pkg::*;
  logic MCLK_IN = 0, RST_IN = 1, AVS_READ_IN = 0, AVS_WRITE_IN = 0, BUS_GRANT_IN = 0;
  logic MEM_ACK_IN = 0, start = 0, p_act, stb_q = 0, saw_br = 0;
  logic [5:0] AVS_ADDRESS_IN = 0;
  logic [31:0] AVS_WRITEDATA_IN = 0, AVS_READDATA_OUT, rq;
  logic AVS_WAITREQUEST_OUT, TRANSFER_REQUEST_N_IN, BUS_REQUEST_OUT, IO_STROBE_OUT;
  logic IO_WRITE_OUT, IO_CONTROL_LINE_TWO_N_OUT, MEM_REQUEST_OUT, MEM_WRITE_OUT;
  logic [3:0] PERIPHERAL_ADDRESS_LINES_OUT;
  logic [15:0] IO_DATA_OUT, IO_DATA_IN, MEM_ADDRESS_OUT, MEM_WRITEDATA_OUT;
  logic [15:0] MEM_READDATA_IN, mem_rd = 0;
  logic [21:0] ioq [$];
  logic [32:0] mq [$];
  int mismatches = 0, cmp_count = 0;
  scdp_dma u_dut (.*);
  scdp_periph_model u_periph (.clk_in(MCLK_IN), .rst_in(RST_IN), .start_in(start),
    .strobe_in(IO_STROBE_OUT), .last_n_in(IO_CONTROL_LINE_TWO_N_OUT),
    .request_n_out(TRANSFER_REQUEST_N_IN), .active_out(p_act), .data_out(IO_DATA_IN));
  initial
  begin
    forever #5 MCLK_IN = ~MCLK_IN;
  end
  // ==========================================================================
  // Bus arbiter, memory and monitor
  // ==========================================================================
  assign MEM_READDATA_IN = MEM_ACK_IN ? mem_rd : ~mem_rd;
  always @(posedge MCLK_IN)
  begin
    MEM_ACK_IN <= MEM_REQUEST_OUT && !MEM_ACK_IN && $urandom_range(1);
    BUS_GRANT_IN <= BUS_REQUEST_OUT && (BUS_GRANT_IN || $urandom_range(1));
    mem_rd <= MEM_ACK_IN ? mem_rd : 16'($urandom);
    if (MEM_REQUEST_OUT && MEM_ACK_IN)
      mq.push_back({MEM_WRITE_OUT, MEM_ADDRESS_OUT, MEM_WRITE_OUT ? MEM_WRITEDATA_OUT : mem_rd});
    if (IO_STROBE_OUT && !stb_q)
      ioq.push_back({IO_WRITE_OUT, IO_CONTROL_LINE_TWO_N_OUT, PERIPHERAL_ADDRESS_LINES_OUT,
        IO_WRITE_OUT ? IO_DATA_OUT : IO_DATA_IN});
    if (BUS_REQUEST_OUT)
      saw_br = 1;
    stb_q = IO_STROBE_OUT;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge MCLK_IN);
    AVS_WRITE_IN <= w;
    AVS_READ_IN <= !w;
    AVS_ADDRESS_IN <= a;
    AVS_WRITEDATA_IN <= d;
    do @(posedge MCLK_IN); while (AVS_WAITREQUEST_OUT !== 1'b0);
    rq = AVS_READDATA_OUT;
    AVS_WRITE_IN <= 0;
    AVS_READ_IN <= 0;
  endtask
  task automatic run_blk(input logic [6:0] c);
    logic a16, out, pul, ign;
    logic [2:0] n;
    logic [15:0] base, ea;
    logic [3:0] sel;
    int t;
    {a16, out, pul, ign, n} = c;
    base = 16'($urandom);
    base[15] = a16 ? !out : out;
    sel = 4'($urandom);
    bus(1, ADDR_CONTROL, {31'h0, a16});
    if (a16)
      bus(1, ADDR_COMMAND, {28'h0, out ? CMD_DIR_SET : CMD_DIR_CLEAR});
    bus(1, ADDR_PERIPH_PTR, {16'h0, 12'($urandom), sel});
    bus(1, ADDR_MEM_PTR, {16'h0, base});
    bus(1, ADDR_WORD_COUNT, {29'h0, n} - 1);
    bus(1, ADDR_COMMAND, {28'h0, ign ? CMD_IGNORE_REQUESTS : pul ? CMD_PULSE_COUNT :
      CMD_TRANSFER_MODE});
    ioq.delete();
    mq.delete();
    saw_br = 0;
    start <= 1;
    @(posedge MCLK_IN);
    start <= 0;
    repeat (2) @(posedge MCLK_IN);
    if (ign)
    begin
      repeat (30) @(posedge MCLK_IN);
      chk("ignored request", 0, saw_br);
      bus(1, ADDR_COMMAND, {28'h0, CMD_TRANSFER_MODE});
    end
    t = 0;
    while ((p_act || BUS_REQUEST_OUT) && t < 3000)
    begin
      @(posedge MCLK_IN);
      t++;
    end
    chk("block ended", 1, t < 3000);
    chk("io cycles", n, ioq.size());
    chk("mem cycles", pul ? 0 : n, mq.size());
    for (int i = 0; i < n; i++)
    begin
      ea = base + 16'(i);
      ea[15] = a16 & ea[15];
      chk("io write", out && !pul, ioq[i][21]);
      chk("last mark", i == n - 1, ioq[i][20]);
      chk("select", sel, ioq[i][19:16]);
      if (!pul)
      begin
        chk("mem address", ea, mq[i][31:16]);
        chk("mem write", !out, mq[i][32]);
        if (out)
          chk("data", mq[i][15:0], ioq[i][15:0]);
        else
          chk("data", ioq[i][15:0], mq[i][15:0]);
      end
    end
    ea = base + 16'(n);
    ea[15] = a16 ? ea[15] : base[15];
    bus(0, ADDR_MEM_PTR, 0);
    chk("pointer", ea, rq);
    bus(0, ADDR_WORD_COUNT, 0);
    chk("count", 32'h0000_FFFF, rq);
    bus(0, ADDR_STATUS, 0);
    chk("status", {26'h0, a16, 2'h0, out, pul, !pul}, rq);
    $display("block %h done", c);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    logic [3:0] cmds [6] = '{4'h3, 4'h1, 4'h3, 4'h2, 4'h3, 4'h7};
    logic [1:0] modes [6] = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h2, 2'h2};
    logic [6:0] cfg [5] = '{7'h0B, 7'h22, 7'h62, 7'h41, 7'h14};
    rq = $urandom(85);
    repeat (4) @(posedge MCLK_IN);
    RST_IN <= 0;
    bus(0, ADDR_STATUS, 0);
    chk("status at reset", 32'h0000_0008, rq);
    chk("line two", 1, IO_CONTROL_LINE_TWO_N_OUT);
    bus(1, 6'h3C, 32'hFFFF_FFFF);
    bus(0, 6'h3C, 0);
    chk("unmapped", 0, rq);
    for (int i = 0; i < 6; i++)
    begin
      bus(1, ADDR_COMMAND, {28'h0, cmds[i]});
      bus(0, ADDR_STATUS, 0);
      chk("mode", modes[i], rq[1:0]);
    end
    $display("mode test done");
    foreach (cfg[i]) run_blk(cfg[i]);
    finish_test();
  end
  initial
  begin
    repeat (50000) @(posedge MCLK_IN);
    mismatches++;
    finish_test();
  end
endmodule
bind scdp_dma scdp_assertions u_chk (.*);
